/* File: verilog/rq_rc_stream_map.vh */
// How it works
// (R1) lookup select picks table entry or raw value
// (R2) user supplies steering value in bits 23:16
// (R3) hint and label fields sampled on first beat
// (R4) label output once request cannot be overtaken
// (R5) user may tie label input to zero
// (R6) user drives odd parity per data byte
// (R7) parity mismatch logs fatal error, drops packet
// (R8) parity bits may be zero when checking off
// (R9) unused completion data lanes driven low
// (R10) 75-bit sideband meaningful only while valid
// (R11) last marks final beat when not straddling
// (R12) last held zero when straddling
// (R13) dword-valid contiguous, full except final beat
// (R14) unused dword-valid bits driven low
// (R15) straddle mode holds dword-valid all ones
// (R16) valid held across the whole packet
// (R17) beat moves on valid and ready; else holds
// (R18) byte-valid marks payload bytes only, contiguous
// (R19) unused byte-valid bits driven low
// (R20) zero-length read completion gets byte-valid bit; code sets bit 12, which the lane mask clears at 64-bit width
// (R21) first start flag on first beat, second zero
// (R22) straddle start at lane 0 or 16
// (R23) second start only after first ends in beat
// (R24) reset keeps valid low, no label pulses
`ifndef RQ_RC_STREAM_MAP_VH
`define RQ_RC_STREAM_MAP_VH

// register offsets (byte addresses)
`define REG_CONTROL_OFS      4'h0
`define REG_STATUS_OFS       4'h4
`define REG_TABLE_INDEX_OFS  4'h8
`define REG_TABLE_DATA_OFS   4'hc

// control fields
`define CTRL_WIDTH_LSB       0
`define CTRL_STRADDLE_BIT    2
`define CTRL_PARITY_EN_BIT   3
`define CTRL_RESET_VALUE     4'h2

// interface width codes
`define WIDTH_64             2'h0
`define WIDTH_128            2'h1
`define WIDTH_256            2'h2

// status fields
`define STAT_FATAL_BIT       0
`define STAT_LABEL_LSB       4
`define STAT_DROPS_LSB       8

// request sideband fields
`define RQ_LOOKUP_SEL_BIT    15
`define RQ_STEER_LSB         16
`define RQ_LABEL_LSB         24
`define RQ_PARITY_LSB        28

// completion sideband fields
`define RC_START0_BIT        32
`define RC_START1_BIT        33
`define RC_UPPER_LSB         34

// steering table
`define TABLE_INDEX_BITS     6
`define TABLE_DEPTH          64

// byte lane of first payload byte after a three-dword descriptor
`define RC_ZERO_LEN_BYTE     12

`endif

/* File: verilog/steer_tag_table.v */
`timescale 1ns/10ps
// steering tag table, one write port and two registered read ports
module steer_tag_table (
  // clock
  input  wire       core_clk_i,
  // write port
  input  wire       wr_en_i,
  input  wire [5:0] wr_addr_i,
  input  wire [7:0] wr_data_i,
  // read ports
  input  wire [5:0] rd_a_addr_i,
  output reg  [7:0] rd_a_data_o,
  input  wire [5:0] rd_b_addr_i,
  output reg  [7:0] rd_b_data_o
);

  reg [7:0] mem [0:63];

  // write and registered reads
  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_a_data_o <= mem[rd_a_addr_i];
    rd_b_data_o <= mem[rd_b_addr_i];
  end

endmodule

/* File: verilog/byte_parity_check.v */
`timescale 1ns/10ps
// odd parity check per data byte, lanes outside the width ignored
module byte_parity_check (
  // beat
  input  wire [255:0] data_i,
  input  wire [31:0]  parity_i,
  input  wire [31:0]  lane_mask_i,
  // result
  output wire         error_o
);

  wire [31:0] lane_bad;

  // a lane is bad when byte and parity bit xor to zero
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_lane
      assign lane_bad[i] = lane_mask_i[i] & ~(^{data_i[8*i+7:8*i], parity_i[i]});
    end
  endgenerate

  assign error_o = |lane_bad;

endmodule

/* File: verilog/requester_request_completion_stream.v */
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rq_rc_stream_map.vh"
// request sideband tail and completion delivery stream
module requester_request_completion_stream (
  // clock and reset
  input  wire         core_clk_i,
  input  wire         reset_n_i,
  // wishbone slave
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [3:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  // request stream from user logic
  input  wire [255:0] request_stream_data_i,
  input  wire [59:0]  request_stream_sideband_i,
  input  wire         request_stream_last_i,
  input  wire         request_stream_valid_i,
  output wire         request_stream_ready_o,
  // request results
  output reg  [3:0]   progress_label_out_o,
  output reg          progress_label_out_valid_o,
  output reg  [7:0]   steering_tag_o,
  output reg          steering_tag_valid_o,
  output reg          request_drop_o,
  output reg          internal_error_o,
  // completion beats from the receive side
  input  wire [255:0] cpl_src_data_i,
  input  wire [31:0]  cpl_src_byte_valid_i,
  input  wire [3:0]   cpl_src_dwords_i,
  input  wire         cpl_src_start_i,
  input  wire         cpl_src_second_start_i,
  input  wire         cpl_src_end_i,
  input  wire         cpl_src_zero_len_i,
  input  wire [40:0]  cpl_src_upper_side_i,
  input  wire         cpl_src_valid_i,
  output wire         cpl_src_ready_o,
  // completion stream to user logic
  output reg  [255:0] completion_stream_data_o,
  output reg  [74:0]  completion_stream_sideband_o,
  output reg          completion_stream_last_o,
  output reg  [7:0]   completion_stream_dword_valid_o,
  output reg          completion_stream_valid_o,
  input  wire         completion_stream_ready_i
);

  // byte lanes that exist at a given width
  function [31:0] lane_mask;
    input [1:0] width;
    begin
      if (width == `WIDTH_64) begin
        lane_mask = 32'h0000_00ff;
      end else if (width == `WIDTH_128) begin
        lane_mask = 32'h0000_ffff;
      end else begin
        lane_mask = 32'hffff_ffff;
      end
    end
  endfunction

  // contiguous dword mask from a count
  function [7:0] dword_mask;
    input [3:0] count;
    begin
      if (count >= 4'h8) begin
        dword_mask = 8'hff;
      end else begin
        dword_mask = ~(8'hff << count[2:0]);
      end
    end
  endfunction

  // configuration and status registers
  reg  [3:0]  control_reg;
  reg  [5:0]  table_index_reg;
  reg  [7:0]  drop_count_reg;
  reg  [3:0]  last_label_reg;
  reg         fatal_reg;
  reg         ack_reg;

  wire [1:0]  width_sel;
  wire        straddle;
  wire        parity_en;
  wire [31:0] lanes;

  assign width_sel = control_reg[`CTRL_WIDTH_LSB+1:`CTRL_WIDTH_LSB];
  assign straddle  = control_reg[`CTRL_STRADDLE_BIT] & (width_sel == `WIDTH_256);
  assign parity_en = control_reg[`CTRL_PARITY_EN_BIT];
  assign lanes     = lane_mask(width_sel);

  // bus access decode
  wire        wb_req;
  wire        wb_write;
  wire        table_write;
  wire [7:0]  table_rd_data;

  assign wb_req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_write    = wb_req & wb_we_i & wb_sel_i[0];
  assign table_write = wb_write & (wb_adr_i == `REG_TABLE_DATA_OFS);

  // register writes and acknowledge, one cycle after the strobe
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      control_reg     <= `CTRL_RESET_VALUE;
      table_index_reg <= 6'h0;
      ack_reg         <= 1'b0;
    end else begin
      ack_reg <= wb_req;
      if (wb_write) begin
        if (wb_adr_i == `REG_CONTROL_OFS) begin
          control_reg <= wb_dat_i[3:0];
        end else if (wb_adr_i == `REG_TABLE_INDEX_OFS) begin
          table_index_reg <= wb_dat_i[5:0];
        end
      end
    end
  end

  // read data, unmapped offsets read zero
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == `REG_CONTROL_OFS) begin
        wb_dat_o <= {28'h000_0000, control_reg};
      end else if (wb_adr_i == `REG_STATUS_OFS) begin
        wb_dat_o <= {16'h0000, drop_count_reg, last_label_reg, 3'h0, fatal_reg};
      end else if (wb_adr_i == `REG_TABLE_INDEX_OFS) begin
        wb_dat_o <= {26'h000_0000, table_index_reg};
      end else if (wb_adr_i == `REG_TABLE_DATA_OFS) begin
        wb_dat_o <= {24'h00_0000, table_rd_data};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  always @* begin
    wb_ack_o = ack_reg;
  end

  // request packet states, one-hot
  localparam [2:0] RQ_FIRST    = 3'b001;
  localparam [2:0] RQ_BODY     = 3'b010;
  localparam [2:0] RQ_BODY_BAD = 3'b100;

  // request side state
  reg  [2:0]  rq_state_reg;
  reg  [2:0]  rq_state_next;
  reg  [3:0]  label_reg;
  reg         lookup_sel_reg;
  reg  [7:0]  steer_raw_reg;
  reg         tag_pending_reg;
  wire        rq_fire;
  wire        first_beat;
  wire        beat_bad;
  wire        packet_bad;
  wire [7:0]  steer_in;
  wire [3:0]  label_in;
  wire [7:0]  table_lookup_data;
  wire [3:0]  label_out;

  assign request_stream_ready_o = 1'b1;
  assign rq_fire    = request_stream_valid_i & request_stream_ready_o;
  assign first_beat = rq_state_reg[0];
  assign steer_in   = request_stream_sideband_i[`RQ_STEER_LSB+7:`RQ_STEER_LSB];
  assign label_in   = request_stream_sideband_i[`RQ_LABEL_LSB+3:`RQ_LABEL_LSB];
  assign packet_bad = rq_state_reg[2] | beat_bad;
  assign label_out  = first_beat ? label_in : label_reg;

  // parity over the lanes in use
  byte_parity_check u_parity (
    .data_i      (request_stream_data_i),
    .parity_i    (request_stream_sideband_i[`RQ_PARITY_LSB+31:`RQ_PARITY_LSB]),
    .lane_mask_i (lanes & {32{parity_en}}),
    .error_o     (beat_bad)
  );

  // steering table, port a for lookups, port b for the bus
  steer_tag_table u_table (
    .core_clk_i  (core_clk_i),
    .wr_en_i     (table_write),
    .wr_addr_i   (table_index_reg),
    .wr_data_i   (wb_dat_i[7:0]),
    .rd_a_addr_i (steer_in[`TABLE_INDEX_BITS-1:0]),
    .rd_a_data_o (table_lookup_data),
    .rd_b_addr_i (table_index_reg),
    .rd_b_data_o (table_rd_data)
  );

  // packet tracking: first beat, body, body after a bad beat
  always @* begin
    rq_state_next = rq_state_reg;
    case (rq_state_reg)
      RQ_FIRST: begin
        if (rq_fire && !request_stream_last_i) begin
          rq_state_next = beat_bad ? RQ_BODY_BAD : RQ_BODY;
        end
      end
      RQ_BODY: begin
        if (rq_fire && request_stream_last_i) begin
          rq_state_next = RQ_FIRST;
        end else if (rq_fire && beat_bad) begin
          rq_state_next = RQ_BODY_BAD; // R7
        end
      end
      RQ_BODY_BAD: begin
        if (rq_fire && request_stream_last_i) begin
          rq_state_next = RQ_FIRST;
        end
      end
      default: begin
        rq_state_next = RQ_FIRST;
      end
    endcase
  end

  // first beat capture and packet state
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rq_state_reg    <= RQ_FIRST;
      label_reg       <= 4'h0;
      lookup_sel_reg  <= 1'b0;
      steer_raw_reg   <= 8'h00;
      tag_pending_reg <= 1'b0;
    end else begin
      rq_state_reg    <= rq_state_next;
      tag_pending_reg <= rq_fire & first_beat;
      if (rq_fire) begin
        if (first_beat) begin
          label_reg      <= label_in; // R3
          lookup_sel_reg <= request_stream_sideband_i[`RQ_LOOKUP_SEL_BIT]; // R3
          steer_raw_reg  <= steer_in; // R3
        end
      end
    end
  end

  // steering tag, table entry or raw value
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      steering_tag_o       <= 8'h00;
      steering_tag_valid_o <= 1'b0;
    end else begin
      steering_tag_valid_o <= tag_pending_reg;
      if (tag_pending_reg) begin
        steering_tag_o <= lookup_sel_reg ? table_lookup_data : steer_raw_reg; // R1
      end
    end
  end

  // label release at packet end, drop and sticky error on bad parity
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      progress_label_out_o       <= 4'h0;
      progress_label_out_valid_o <= 1'b0; // R24
      request_drop_o             <= 1'b0;
      internal_error_o           <= 1'b0;
      fatal_reg                  <= 1'b0;
      drop_count_reg             <= 8'h00;
      last_label_reg             <= 4'h0;
    end else begin
      progress_label_out_valid_o <= 1'b0;
      request_drop_o             <= 1'b0;
      if (rq_fire && beat_bad) begin
        fatal_reg        <= 1'b1; // R7
        internal_error_o <= 1'b1; // R7
      end
      if (rq_fire && request_stream_last_i) begin
        if (packet_bad) begin
          request_drop_o <= 1'b1; // R7
          drop_count_reg <= drop_count_reg + 8'h01;
        end else begin
          progress_label_out_valid_o <= 1'b1; // R4
          progress_label_out_o       <= label_out; // R4
          last_label_reg             <= label_out;
        end
      end
    end
  end

  // completion beat shaping
  reg  [31:0]  cpl_byte_valid;
  reg  [7:0]   cpl_dwords;
  reg  [255:0] cpl_data;
  wire         cpl_load;

  assign cpl_src_ready_o = ~completion_stream_valid_o | completion_stream_ready_i; // R17
  assign cpl_load        = cpl_src_valid_i & cpl_src_ready_o;

  // data lanes beyond the width forced low
  genvar b;
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_data_lane
      always @* begin
        cpl_data[8*b+7:8*b] = cpl_src_data_i[8*b+7:8*b] & {8{lanes[b]}}; // R9
      end
    end
  endgenerate

  // byte-valid and dword-valid for the width and mode
  always @* begin
    cpl_byte_valid = cpl_src_byte_valid_i;
    if (cpl_src_zero_len_i) begin
      cpl_byte_valid[`RC_ZERO_LEN_BYTE] = 1'b1; // R20
    end
    cpl_byte_valid = cpl_byte_valid & lanes; // R18 R19
    if (straddle) begin
      cpl_dwords = 8'hff; // R15
    end else if (width_sel == `WIDTH_64) begin
      cpl_dwords = dword_mask(cpl_src_dwords_i) & 8'h03; // R13 R14
    end else if (width_sel == `WIDTH_128) begin
      cpl_dwords = dword_mask(cpl_src_dwords_i) & 8'h0f; // R13 R14
    end else begin
      cpl_dwords = dword_mask(cpl_src_dwords_i); // R13
    end
  end

  // output register, held while the user stalls
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      completion_stream_valid_o       <= 1'b0; // R24
      completion_stream_data_o        <= 256'h0;
      completion_stream_sideband_o    <= 75'h0;
      completion_stream_last_o        <= 1'b0;
      completion_stream_dword_valid_o <= 8'h00;
    end else if (cpl_src_ready_o) begin
      completion_stream_valid_o <= cpl_src_valid_i; // R16 R17
      if (cpl_load) begin
        completion_stream_data_o                         <= cpl_data;
        completion_stream_sideband_o[31:0]               <= cpl_byte_valid; // R10
        completion_stream_sideband_o[`RC_START0_BIT]     <= cpl_src_start_i; // R21 R22
        completion_stream_sideband_o[`RC_START1_BIT]     <= straddle & cpl_src_second_start_i
                                                            & cpl_src_start_i & cpl_src_end_i; // R21 R23
        completion_stream_sideband_o[74:`RC_UPPER_LSB]   <= cpl_src_upper_side_i;
        completion_stream_last_o                         <= cpl_src_end_i & ~straddle; // R11 R12
        completion_stream_dword_valid_o                  <= cpl_dwords;
      end
    end
  end

endmodule

/* File: verification/rrcs_sva.sv */
`timescale 1ns/10ps
// request results and completion stream checks
module rrcs_sva (
  // clock and reset
  input wire logic         core_clk_i,
  input wire logic         reset_n_i,
  // request side
  input wire logic         request_stream_valid_i,
  input wire logic         request_stream_last_i,
  input wire logic         progress_label_out_valid_o,
  input wire logic         steering_tag_valid_o,
  input wire logic         request_drop_o,
  input wire logic         internal_error_o,
  // completion side
  input wire logic         cpl_src_ready_o,
  input wire logic [255:0] completion_stream_data_o,
  input wire logic [74:0]  completion_stream_sideband_o,
  input wire logic         completion_stream_last_o,
  input wire logic [7:0]   completion_stream_dword_valid_o,
  input wire logic         completion_stream_valid_o,
  input wire logic         completion_stream_ready_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic mid_reg;
  // high between first and last beat of a request
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) mid_reg <= 1'b0;
    else if (request_stream_valid_i) mid_reg <= !request_stream_last_i;
  end
  // stream steps
  sequence first_beat_s;
    request_stream_valid_i && !mid_reg;
  endsequence
  sequence stalled_s;
    completion_stream_valid_o && !completion_stream_ready_i;
  endsequence
  tag_after_first_a: assert property (first_beat_s |-> ##2 (steering_tag_valid_o || internal_error_o))
    else $error("no steering tag after first beat");
  label_after_last_a: assert property (request_stream_valid_i && request_stream_last_i |=>
    progress_label_out_valid_o ^ request_drop_o)
    else $error("no label or drop after last beat");
  drop_marks_error_a: assert property (request_drop_o |-> internal_error_o)
    else $error("drop without fatal error");
  error_sticky_a: assert property (internal_error_o |=> internal_error_o)
    else $error("fatal error cleared without reset");
  reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=>
    !completion_stream_valid_o && !progress_label_out_valid_o)
    else $error("output active during reset");
  stall_hold_a: assert property (stalled_s |=> completion_stream_valid_o && $stable(completion_stream_data_o)
    && $stable(completion_stream_sideband_o))
    else $error("completion beat changed while stalled");
  source_pace_a: assert property (cpl_src_ready_o == (!completion_stream_valid_o || completion_stream_ready_i))
    else $error("source ready wrong");
  dword_contig_a: assert property (completion_stream_valid_o |-> completion_stream_dword_valid_o[0] &&
    (((completion_stream_dword_valid_o + 8'h01) & completion_stream_dword_valid_o) == 8'h00))
    else $error("dword valid not contiguous");
  second_start_a: assert property (completion_stream_valid_o && completion_stream_sideband_o[33] |->
    completion_stream_sideband_o[32] && !completion_stream_last_o && &completion_stream_dword_valid_o)
    else $error("second start without straddle framing");
endmodule

/* File: verification/user_app_model.sv */
`timescale 1ns/10ps
// user logic: issues requests, consumes completions
module user_app_model (
  // clock and reset
  input  wire logic    core_clk_i,
  input  wire logic    reset_n_i,
  // request stream
  output logic [255:0] request_stream_data_i,
  output logic [59:0]  request_stream_sideband_i,
  output logic         request_stream_last_i,
  output logic         request_stream_valid_i,
  input  wire logic    request_stream_ready_o,
  // completion throttle
  input  wire logic    app_stall_i,
  output logic         completion_stream_ready_i
);
  logic [1:0] pace_reg;
  logic       par_off = 1'b0;
  initial request_stream_valid_i = 1'b0;
  // one ready cycle in four while stalling
  always_ff @(posedge core_clk_i) begin
    pace_reg <= reset_n_i ? pace_reg + 2'h1 : 2'h0;
  end
  assign completion_stream_ready_i = !app_stall_i || (pace_reg == 2'h3);
  // odd parity per data byte
  function automatic logic [31:0] odd_par(input logic [255:0] d);
    for (int i = 0; i < 32; i++) odd_par[i] = ~^d[8*i +: 8];
  endfunction
  // one packet; later beats carry altered header fields
  task automatic send(input logic sel, input logic [7:0] st, input logic [3:0] lab, input int beats,
                      input logic bad);
    logic [255:0] d;
    for (int b = 0; b < beats; b++) begin
      d = {8{32'h3c5a_0f10 + b}};
      request_stream_data_i <= d;
      request_stream_sideband_i <= {(odd_par(d) & {32{!par_off}}) ^ {31'h0, bad && b == 0}, lab ^ b[3:0],
                                    st ^ b[7:0], sel ^ (b != 0), 15'h0};
      request_stream_last_i <= (b == beats - 1);
      request_stream_valid_i <= 1'b1;
      @(posedge core_clk_i);
      for (int w = 0; w < 64 && request_stream_ready_o !== 1'b1; w++) @(posedge core_clk_i);
      if (request_stream_ready_o !== 1'b1) tb_requester_request_completion_stream.expire();
    end
    request_stream_valid_i <= 1'b0;
    request_stream_data_i <= ~d;
    @(posedge core_clk_i);
  endtask
endmodule

/* File: verification/tb_requester_request_completion_stream.sv */
`timescale 1ns/10ps
`include "rq_rc_stream_map.vh"
module tb_requester_request_completion_stream;
  // clock, reset, bus
  logic         core_clk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0]   wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0]  wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  // request side
  logic [255:0] request_stream_data_i;
  logic [59:0]  request_stream_sideband_i;
  logic         request_stream_last_i, request_stream_valid_i, request_stream_ready_o;
  logic [3:0]   progress_label_out_o;
  logic [7:0]   steering_tag_o;
  logic         progress_label_out_valid_o, steering_tag_valid_o, request_drop_o, internal_error_o;
  // completion source and stream
  logic [255:0] cpl_src_data_i = '0, completion_stream_data_o, seen_data;
  logic [31:0]  cpl_src_byte_valid_i = '0;
  logic [3:0]   cpl_src_dwords_i = 4'h0;
  logic         cpl_src_start_i = 1'b0, cpl_src_second_start_i = 1'b0, cpl_src_end_i = 1'b0;
  logic         cpl_src_zero_len_i = 1'b0, cpl_src_valid_i = 1'b0, cpl_src_ready_o, app_stall_i = 1'b0;
  logic [40:0]  cpl_src_upper_side_i = 41'h1_2345_6789;
  logic [74:0]  completion_stream_sideband_o, seen_side;
  logic [7:0]   completion_stream_dword_valid_o, seen_dv;
  logic         completion_stream_last_o, completion_stream_valid_o, completion_stream_ready_i, seen_last;
  // bench state
  int           n_errors = 0, samples_checked = 0, n_cpl = 0, n_drop = 0;
  logic [3:0]   lab_q[$];
  logic [7:0]   tag_q[$];
  localparam logic [10:0] rows [6] = '{11'h48a, 11'h23c, 11'h082, 11'h52e, 11'h43b, 11'h282};

  requester_request_completion_stream u_dut (.*);
  user_app_model u_app (.*);

  initial forever #2 core_clk_i = ~core_clk_i;

  // capture pulses and accepted completion beats
  always @(posedge core_clk_i) begin
    if (progress_label_out_valid_o === 1'b1) lab_q.push_back(progress_label_out_o);
    if (steering_tag_valid_o === 1'b1) tag_q.push_back(steering_tag_o);
    if (request_drop_o === 1'b1) n_drop <= n_drop + 1;
    if (completion_stream_valid_o === 1'b1 && completion_stream_ready_i === 1'b1) begin
      seen_data <= completion_stream_data_o;
      seen_side <= completion_stream_sideband_o;
      seen_dv <= completion_stream_dword_valid_o;
      seen_last <= completion_stream_last_o;
      n_cpl <= n_cpl + 1;
    end
  end

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic expire;
    n_errors++;
    complete_run;
  endtask

  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset;
    reset_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
  endtask

  // classic single wishbone cycle
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (int w = 0; w <= 32; w++) begin
      @(posedge core_clk_i);
      if (wb_ack_o === 1'b1) break;
      if (w == 32) expire;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // two back-to-back source beats, then wait for both at the user side
  task automatic cpl_pair(input logic [10:0] r);
    int k;
    int n;
    k = n_cpl;
    n = 0;
    cpl_src_data_i <= {8{32'ha5c3_5a3c}};
    cpl_src_byte_valid_i <= r[0] ? 32'h0000_0000 : 32'hffff_f000;
    cpl_src_dwords_i <= r[7:4];
    {cpl_src_start_i, cpl_src_second_start_i, cpl_src_end_i, cpl_src_zero_len_i} <= r[3:0];
    cpl_src_valid_i <= 1'b1;
    for (int t = 0; t < 200 && n < 2; t++) begin
      @(posedge core_clk_i);
      n += (cpl_src_ready_o === 1'b1);
    end
    cpl_src_valid_i <= 1'b0;
    for (int t = 0; t < 200 && n_cpl < k + 2; t++) @(posedge core_clk_i);
    if (n_cpl < k + 2) expire;
  endtask

  task automatic pull(input logic [3:0] el, input logic [7:0] et);
    chk("label", el, lab_q.size() > 0 ? lab_q.pop_front() : 4'hx);
    chk("tag", et, tag_q.size() > 0 ? tag_q.pop_front() : 8'hx);
  endtask

  initial begin
    logic [255:0] dm;
    logic [74:0]  es;
    logic [31:0]  bm;
    do_reset();
    chk("idle valid", 1'b0, completion_stream_valid_o);
    wb_xfer(1'b0, `REG_CONTROL_OFS, 32'h0, rd);
    chk("control reset", 32'h0000_0002, rd);
    $display("reset test done");
    // completion rows: width, straddle, dwords, flags
    for (int i = 0; i < 6; i++) begin
      app_stall_i <= i[0];
      wb_xfer(1'b1, `REG_CONTROL_OFS, {29'h0, rows[i][8], rows[i][10:9]}, rd);
      cpl_pair(rows[i]);
      dm = rows[i][10:9] == 2'h0 ? {192'h0, {64{1'b1}}} : rows[i][10:9] == 2'h1 ? {128'h0, {128{1'b1}}} : '1;
      bm = dm[255:224] | {24'h0, {8{dm[0]}}} | {16'h0, {16{dm[127]}}};
      es = {cpl_src_upper_side_i, &rows[i][3:1] & rows[i][8], rows[i][3],
            (rows[i][0] ? 32'h0000_1000 : 32'hffff_f000) & bm};
      chk("data", {8{32'ha5c3_5a3c}} & dm, seen_data);
      chk("sideband", es, seen_side);
      chk("dword_valid", rows[i][8] ? 8'hff : (8'hff >> (4'h8 - rows[i][7:4])) &
          {bm[28], bm[24], bm[20], bm[16], bm[12], bm[8], bm[4], bm[0]}, seen_dv);
      chk("last", rows[i][1] & !rows[i][8], seen_last);
      $display("row %0d done", i);
    end
    // direct and table steering, first-beat capture
    do_reset();
    wb_xfer(1'b1, `REG_TABLE_INDEX_OFS, 32'h0000_0005, rd);
    wb_xfer(1'b1, `REG_TABLE_DATA_OFS, 32'h0000_0077, rd);
    wb_xfer(1'b0, `REG_TABLE_DATA_OFS, 32'h0, rd);
    chk("table entry", 32'h0000_0077, rd);
    u_app.par_off = 1'b1;
    u_app.send(1'b0, 8'h5a, 4'h3, 1, 1'b0);
    u_app.send(1'b1, 8'hc5, 4'h6, 3, 1'b0);
    repeat (4) @(posedge core_clk_i);
    pull(4'h3, 8'h5a);
    pull(4'h6, 8'h77);
    $display("steering test done");
    // parity check on, one bad packet between good ones
    wb_xfer(1'b1, `REG_CONTROL_OFS, 32'h0000_000a, rd);
    lab_q.delete();
    u_app.par_off = 1'b0;
    u_app.send(1'b0, 8'h11, 4'h0, 1, 1'b0);
    u_app.send(1'b0, 8'h22, 4'h4, 2, 1'b1);
    u_app.send(1'b0, 8'h33, 4'h5, 1, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk("drops", 1, n_drop);
    chk("labels", 2, lab_q.size());
    chk("error", 1'b1, internal_error_o);
    wb_xfer(1'b0, `REG_STATUS_OFS, 32'h0, rd);
    chk("status", 32'h0000_0151, rd & 32'h0000_fff1);
    wb_xfer(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0000_0000, rd);
    do_reset();
    chk("error after reset", 1'b0, internal_error_o);
    $display("parity test done");
    complete_run;
  end
endmodule

bind requester_request_completion_stream rrcs_sva u_sva (.*);
